// ===== common/sacc_pkg.sv
// Purpose: Shared constants for the converter clock and configuration block.
// Assumes: 32-bit APB data, one register per aligned word, 10 MHz system clock.
// Notes: All offsets and phase counts live here, with most field positions and the reset values of multi-bit registers.
package sacc_pkg;

  // Widths of the converter datapath and configuration fields.
  localparam int RES_W = 10;
  localparam int CHAN_W = 6;
  localparam int DIV_W = 6;
  localparam int PREF_W = 3;
  localparam int ADDR_W = 8;
  localparam int STAT_W = 2;

  // Register byte offsets on the APB side.
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CHAN = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_REF = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CLKDIV = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_RESH = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_RESL = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_THR = 8'h20;

  // Bit positions in converter_control_zero.
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_CONT_BIT = 2;
  localparam int CTRL_RCSEL_BIT = 4;

  // Field positions in reference_select_reg.
  localparam int REF_POS_LSB = 0;
  localparam int REF_NEG_BIT = 4;

  // Bit positions in the status and mask registers.
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_THR_BIT = 1;

  // Codes of positive_ref_field.
  localparam logic [PREF_W-1:0] PREF_SUPPLY = 3'h0;
  localparam logic [PREF_W-1:0] PREF_PIN = 3'h1;
  localparam logic [PREF_W-1:0] PREF_FVR_1V024 = 3'h2;
  localparam logic [PREF_W-1:0] PREF_FVR_2V048 = 3'h3;
  localparam logic [PREF_W-1:0] PREF_FVR_4V096 = 3'h4;

  // Reset values of the software registers.
  localparam logic [CHAN_W-1:0] CHAN_RST = 6'h00;
  localparam logic [PREF_W-1:0] PREF_RST = 3'h0;
  localparam logic [DIV_W-1:0] DIV_RST = 6'h00;
  localparam logic [RES_W-1:0] RES_RST = 10'h000;
  localparam logic [RES_W-1:0] THR_RST = 10'h3FF;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;

  // Conversion length in half bit periods: 1.5 periods of sampling, 10 bits of two halves.
  localparam int ACQ_HALVES = 3;
  localparam int BIT_HALVES = 2;
  localparam int CONV_HALVES = ACQ_HALVES + BIT_HALVES * RES_W;
  localparam logic [1:0] ACQ_LAST = 2'(ACQ_HALVES - 1);
  localparam logic [3:0] MSB_IDX = 4'(RES_W - 1);

  // States of the successive-approximation sequencer.
  typedef enum logic [1:0] {S_IDLE, S_ACQ, S_SET, S_JUDGE} sacc_state_t;

endpackage : sacc_pkg

// ===== rtl/sacc_clkdiv.sv
// Purpose: Half bit-period tick generator for the converter.
// Assumes: rc_level_i is already synchronised to clock_i.
// Notes: One half tick every n+1 system clocks, so a bit period is 2*(n+1) clocks.
`timescale 1ns/1ps
module sacc_clkdiv
  import sacc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [DIV_W-1:0] div_n_i,
  input wire logic rc_sel_i,
  input wire logic rc_level_i,
  input wire logic run_i,
  output logic half_tick_o
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic rc_prev;
  logic next_rc_prev;
  logic next_half_tick;

  // Selects the tick source and reloads the down-counter from the divider field.
  always_comb begin
    next_cnt = cnt;
    next_half_tick = 1'b0;
    next_rc_prev = rc_level_i;
    if (!run_i) begin
      next_cnt = div_n_i;
    end else if (rc_sel_i) begin
      next_half_tick = rc_level_i & ~rc_prev;
    end else if (cnt == '0) begin
      next_half_tick = 1'b1;
      next_cnt = div_n_i;
    end else begin
      next_cnt = cnt - 6'h01;
    end
  end

  // Registers the counter, the edge memory and the tick.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= DIV_RST;
      rc_prev <= 1'b0;
      half_tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      rc_prev <= next_rc_prev;
      half_tick_o <= next_half_tick;
    end
  end

endmodule : sacc_clkdiv

// ===== rtl/sacc_sar.sv
// Purpose: Successive-approximation sequencer for a 10-bit conversion.
// Assumes: comp_i is synchronised; high means input at or above the trial code.
// Notes: A conversion spans 23 half ticks; abort drops the conversion at once.
`timescale 1ns/1ps
module sacc_sar
  import sacc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic half_tick_i,
  input wire logic comp_i,
  output logic busy_o,
  output logic sample_o,
  output logic done_o,
  output logic [RES_W-1:0] trial_o,
  output logic [RES_W-1:0] result_o
);

  sacc_state_t state;
  sacc_state_t next_state;
  logic [1:0] acq_cnt;
  logic [1:0] next_acq_cnt;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [RES_W-1:0] next_trial;
  logic [RES_W-1:0] next_result;
  logic next_done;

  // Steps through sampling and one trial bit per bit period.
  always_comb begin
    logic [RES_W-1:0] judged;
    judged = trial_o;
    next_state = state;
    next_acq_cnt = acq_cnt;
    next_bit_idx = bit_idx;
    next_trial = trial_o;
    next_result = result_o;
    next_done = 1'b0;
    case (state)
      S_IDLE: begin
        if (start_i) begin
          next_state = S_ACQ;
          next_acq_cnt = 2'h0;
          next_trial = RES_RST;
        end
      end
      S_ACQ: begin
        if (half_tick_i) begin
          if (acq_cnt == ACQ_LAST) begin
            next_state = S_SET;
            next_bit_idx = MSB_IDX;
            next_trial = RES_RST;
            next_trial[MSB_IDX] = 1'b1;
          end else begin
            next_acq_cnt = acq_cnt + 2'h1;
          end
        end
      end
      S_SET: begin
        if (half_tick_i) begin
          next_state = S_JUDGE;
        end
      end
      S_JUDGE: begin
        if (half_tick_i) begin
          if (!comp_i) begin
            judged[bit_idx] = 1'b0;
          end
          next_trial = judged;
          if (bit_idx == 4'h0) begin
            next_state = S_IDLE;
            next_result = judged;
            next_done = 1'b1;
          end else begin
            next_trial[bit_idx - 4'h1] = 1'b1;
            next_bit_idx = bit_idx - 4'h1;
            next_state = S_SET;
          end
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (abort_i && state != S_IDLE) begin
      next_state = S_IDLE;
      next_done = 1'b0;
    end
  end

  // Registers sequencer state and its decoded outputs.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= S_IDLE;
      acq_cnt <= 2'h0;
      bit_idx <= 4'h0;
      trial_o <= RES_RST;
      result_o <= RES_RST;
      done_o <= 1'b0;
      busy_o <= 1'b0;
      sample_o <= 1'b0;
    end else begin
      state <= next_state;
      acq_cnt <= next_acq_cnt;
      bit_idx <= next_bit_idx;
      trial_o <= next_trial;
      result_o <= next_result;
      done_o <= next_done;
      busy_o <= (next_state != S_IDLE);
      sample_o <= (next_state == S_ACQ);
    end
  end

endmodule : sacc_sar

// ===== rtl/sacc_top.sv
// Purpose: Converter configuration, conversion clock and control with an APB register file.
// Assumes: rc_osc_i, comparator_i and sleep_i are asynchronous pins.
// Notes: Reads answer with a one-cycle setup latch; access phase completes in one cycle.
`timescale 1ns/1ps

// Overview of operation
// - Resolve each conversion to 10 bits by successive approximation into result bytes.
// - All selectable inputs share one multiplexer and one sample-and-hold stage.
// - Channel select register chooses which input drives the sample-and-hold.
// - Reference field picks positive reference: pin, supply, or fixed 1.024/2.048/4.096 V.
// - One reference bit picks negative reference: external pin or ground.
// - System path bit period is system clock divided by 2*(n+1), n six bits.
// - Control bit 4 set selects the RC oscillator, otherwise the divided clock.
// - A full 10-bit conversion lasts exactly 11.5 bit periods on the divided clock, 11 to 11.5 on the RC clock.
// - Converter control runs from the system clock; RC mode only paces the conversion steps, so changes are not delayed.
// - Without RC oscillator, conversion clock follows system clock changes directly.
// - Completion and threshold raise interrupts; either can wake from sleep.
// - On completion clear go unless continuous, set flag, update results.
// - Done flag sets after every conversion regardless of interrupt mask.
module sacc_top
  import sacc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rc_osc_i,
  input wire logic comparator_i,
  input wire logic sleep_i,
  output logic [CHAN_W-1:0] channel_sel_o,
  output logic [PREF_W-1:0] pos_ref_sel_o,
  output logic neg_ref_sel_o,
  output logic sample_hold_o,
  output logic [RES_W-1:0] dac_trial_o,
  output logic irq_o,
  output logic wake_o
);

  // Software-visible state.
  logic ctrl_on;
  logic go;
  logic cont;
  logic rc_sel;
  logic [DIV_W-1:0] div_n;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [RES_W-1:0] thr;
  logic next_ctrl_on;
  logic next_go;
  logic next_cont;
  logic next_rc_sel;
  logic [CHAN_W-1:0] next_chan;
  logic [PREF_W-1:0] next_pref;
  logic next_nref;
  logic [DIV_W-1:0] next_div_n;
  logic [STAT_W-1:0] next_status;
  logic [STAT_W-1:0] next_mask;
  logic [RES_W-1:0] next_thr;
  logic next_irq;
  logic next_wake;

  // Bus answer state.
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // Pin synchronisers: first stage feeds only the second.
  logic [2:0] sync_1;
  logic [2:0] sync_2;
  logic rc_level;
  logic comp_level;
  logic sleep_level;

  // Sequencer and divider wiring.
  logic half_tick;
  logic sar_busy;
  logic sar_done;
  logic [RES_W-1:0] sar_result;
  logic sar_start;
  logic sar_abort;
  logic div_run;

  // Bus decode terms.
  logic setup_phase;
  logic wr_access;
  logic [STAT_W-1:0] events;
  logic [STAT_W-1:0] clear_bits;

  // Two flip-flop synchronisers for the asynchronous pins.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_1 <= 3'h0;
      sync_2 <= 3'h0;
    end else begin
      sync_1 <= {sleep_i, comparator_i, rc_osc_i};
      sync_2 <= sync_1;
    end
  end

  assign rc_level = sync_2[0];
  assign comp_level = sync_2[1];
  assign sleep_level = sync_2[2];

  // Ticks run only while converting, so the first divided half period is whole; sleep keeps only RC.
  assign div_run = sar_busy & (~sleep_level | rc_sel);

  // Tick generator for the chosen conversion clock.
  sacc_clkdiv u_clkdiv (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .div_n_i(div_n),
    .rc_sel_i(rc_sel),
    .rc_level_i(rc_level),
    .run_i(div_run),
    .half_tick_o(half_tick)
  );

  // Start needs go and enable; the done cycle is skipped so single mode does not rerun.
  assign sar_start = go & ctrl_on & ~sar_busy & ~sar_done;
  assign sar_abort = sar_busy & ~(go & ctrl_on);

  // Successive-approximation sequencer.
  sacc_sar u_sar (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .start_i(sar_start),
    .abort_i(sar_abort),
    .half_tick_i(half_tick),
    .comp_i(comp_level),
    .busy_o(sar_busy),
    .sample_o(sample_hold_o),
    .done_o(sar_done),
    .trial_o(dac_trial_o),
    .result_o(sar_result)
  );

  assign setup_phase = psel_i & ~penable_i;
  assign wr_access = psel_i & penable_i & pready_o & pwrite_i;

  // Completion and threshold events; the done flag ignores the mask.
  always_comb begin
    events = STAT_RST;
    events[STAT_DONE_BIT] = sar_done;
    events[STAT_THR_BIT] = sar_done & (sar_result >= thr);
  end

  // Write-one-to-clear bits taken from a status write.
  assign clear_bits = (wr_access && paddr_i == ADDR_STAT) ? pwdata_i[STAT_W-1:0] : STAT_RST;

  // Next values of the software registers, with hardware updates.
  always_comb begin
    next_ctrl_on = ctrl_on;
    next_go = go;
    next_cont = cont;
    next_rc_sel = rc_sel;
    next_chan = channel_sel_o;
    next_pref = pos_ref_sel_o;
    next_nref = neg_ref_sel_o;
    next_div_n = div_n;
    next_mask = mask;
    next_thr = thr;
    if (sar_done && !cont) begin
      next_go = 1'b0;
    end
    if (wr_access) begin
      case (paddr_i)
        ADDR_CTRL: begin
          next_ctrl_on = pwdata_i[CTRL_ON_BIT];
          next_go = pwdata_i[CTRL_GO_BIT];
          next_cont = pwdata_i[CTRL_CONT_BIT];
          next_rc_sel = pwdata_i[CTRL_RCSEL_BIT];
        end
        ADDR_CHAN: next_chan = pwdata_i[CHAN_W-1:0];
        ADDR_REF: begin
          next_pref = pwdata_i[REF_POS_LSB +: PREF_W];
          next_nref = pwdata_i[REF_NEG_BIT];
        end
        ADDR_CLKDIV: next_div_n = pwdata_i[DIV_W-1:0];
        ADDR_MASK: next_mask = pwdata_i[STAT_W-1:0];
        ADDR_THR: next_thr = pwdata_i[RES_W-1:0];
        default: begin
          next_thr = thr;
        end
      endcase
    end
    // A new event wins over a clear in the same cycle.
    next_status = (status & ~clear_bits) | events;
    next_irq = |(next_status & mask);
    next_wake = sleep_level & |(next_status & mask);
  end

  // Read data and slave error are latched in the setup phase.
  always_comb begin
    next_prdata = prdata_o;
    next_pslverr = 1'b0;
    next_pready = setup_phase;
    if (setup_phase) begin
      next_prdata = 32'h0000_0000;
      case (paddr_i)
        ADDR_CTRL: begin
          next_prdata[CTRL_ON_BIT] = ctrl_on;
          next_prdata[CTRL_GO_BIT] = go;
          next_prdata[CTRL_CONT_BIT] = cont;
          next_prdata[CTRL_RCSEL_BIT] = rc_sel;
        end
        ADDR_CHAN: next_prdata[CHAN_W-1:0] = channel_sel_o;
        ADDR_REF: begin
          next_prdata[REF_POS_LSB +: PREF_W] = pos_ref_sel_o;
          next_prdata[REF_NEG_BIT] = neg_ref_sel_o;
        end
        ADDR_CLKDIV: next_prdata[DIV_W-1:0] = div_n;
        ADDR_RESH: next_prdata[1:0] = sar_result[RES_W-1:8];
        ADDR_RESL: next_prdata[7:0] = sar_result[7:0];
        ADDR_STAT: next_prdata[STAT_W-1:0] = status;
        ADDR_MASK: next_prdata[STAT_W-1:0] = mask;
        ADDR_THR: next_prdata[RES_W-1:0] = thr;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // Registers all software state and every bus and interrupt output.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_on <= 1'b0;
      go <= 1'b0;
      cont <= 1'b0;
      rc_sel <= 1'b0;
      channel_sel_o <= CHAN_RST;
      pos_ref_sel_o <= PREF_RST;
      neg_ref_sel_o <= 1'b0;
      div_n <= DIV_RST;
      status <= STAT_RST;
      mask <= STAT_RST;
      thr <= THR_RST;
      irq_o <= 1'b0;
      wake_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      ctrl_on <= next_ctrl_on;
      go <= next_go;
      cont <= next_cont;
      rc_sel <= next_rc_sel;
      channel_sel_o <= next_chan;
      pos_ref_sel_o <= next_pref;
      neg_ref_sel_o <= next_nref;
      div_n <= next_div_n;
      status <= next_status;
      mask <= next_mask;
      thr <= next_thr;
      irq_o <= next_irq;
      wake_o <= next_wake;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end

endmodule : sacc_top

// ===== sim/sacc_partner.sv
// Purpose: Analog far side: channel levels, comparator and RC oscillator.
// Assumes: The level on a channel is the channel number followed by 4'h5.
// Notes: The RC clock stands still low while the bench does not run it.
`timescale 1ns/1ps
module sacc_partner
  import sacc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rc_run_i,
  input wire logic [CHAN_W-1:0] channel_i,
  input wire logic [RES_W-1:0] trial_i,
  output logic comp_o,
  output logic rc_osc_o
);
  logic [2:0] rc_cnt = 3'h0;
  logic [2:0] next_rc_cnt;
  // The chosen input reaches the one hold stage and is compared with the trial code.
  assign comp_o = {channel_i, 4'h5} >= trial_i;
  // One RC rising edge every eight system clocks, slow enough to be synchronised.
  always_comb begin
    next_rc_cnt = rc_run_i ? rc_cnt + 3'h1 : 3'h0;
  end
  always_ff @(posedge clock_i) begin
    rc_cnt <= next_rc_cnt;
  end
  assign rc_osc_o = rc_cnt[2];
endmodule : sacc_partner

// ===== sim/sacc_assertions.sv
// Purpose: Port-level timing checks for the converter block.
// Assumes: Divider and clock select are shadowed from APB writes.
// Notes: Sampling length is judged on the divided clock only.
`timescale 1ns/1ps
module sacc_assertions
  import sacc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [CHAN_W-1:0] channel_sel_o,
  input wire logic [PREF_W-1:0] pos_ref_sel_o,
  input wire logic neg_ref_sel_o,
  input wire logic sample_hold_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  logic wr;
  logic [DIV_W-1:0] div_n, next_div_n;
  logic rc_sel, next_rc_sel;
  logic [8:0] sh_cnt, next_sh_cnt;
  assign wr = psel_i && penable_i && pready_o && pwrite_i;
  // Shadow divider and clock select, and count the cycles of sampling.
  always_comb begin
    next_div_n = (wr && paddr_i == ADDR_CLKDIV) ? pwdata_i[DIV_W-1:0] : div_n;
    next_rc_sel = (wr && paddr_i == ADDR_CTRL) ? pwdata_i[CTRL_RCSEL_BIT] : rc_sel;
    next_sh_cnt = sample_hold_o ? sh_cnt + 9'h1 : 9'h0;
  end
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_n <= DIV_RST;
      rc_sel <= 1'h0;
      sh_cnt <= 9'h0;
    end else begin
      div_n <= next_div_n;
      rc_sel <= next_rc_sel;
      sh_cnt <= next_sh_cnt;
    end
  end
  a_ready_answer: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no pready after setup");
  a_unmapped_error: assert property (psel_i && !penable_i && paddr_i > ADDR_THR |=> pslverr_o)
    else $error("unmapped address not refused");
  a_channel_write: assert property (wr && paddr_i == ADDR_CHAN |=>
    channel_sel_o == $past(pwdata_i[CHAN_W-1:0])) else $error("channel not written");
  a_channel_hold: assert property (!$stable(channel_sel_o) |->
    $past(wr && paddr_i == ADDR_CHAN)) else $error("channel changed by itself");
  a_ref_write: assert property (wr && paddr_i == ADDR_REF |=>
    pos_ref_sel_o == $past(pwdata_i[2:0]) && neg_ref_sel_o == $past(pwdata_i[REF_NEG_BIT]))
    else $error("reference select not written");
  a_sample_len: assert property ($fell(sample_hold_o) && !rc_sel |->
    sh_cnt >= 9'(3 * div_n + 2) && sh_cnt <= 9'(3 * div_n + 4)) else $error("sampling length off");
  a_wake_irq: assert property (wake_o |-> irq_o)
    else $error("wake without interrupt");
  a_irq_masked: assert property (wr && paddr_i == ADDR_MASK && pwdata_i[1:0] == 2'h0 |->
    ##2 !irq_o) else $error("masked interrupt still high");
  cover property ($rose(irq_o));
  cover property ($rose(wake_o));
  cover property (pslverr_o);
endmodule : sacc_assertions

bind sacc_top sacc_assertions chk (.clock_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .channel_sel_o, .pos_ref_sel_o,
  .neg_ref_sel_o, .sample_hold_o, .irq_o, .wake_o);

// ===== sim/test_sar_adc_clock_and_config.sv
// Purpose: Self-checking bench for the converter clock and configuration block.
// Assumes: The far side is sacc_partner; registers are reached over APB.
// Notes: Register rows run in one loop; conversions and aborts follow by hand.
`timescale 1ns/1ps
module test_sar_adc_clock_and_config;
  import sacc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} sacc_row_t;
  logic clock_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [ADDR_W-1:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic sleep_i = 1'h0;
  logic rc_run = 1'h0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, rc_osc_i, comparator_i, neg_ref_sel_o;
  logic sample_hold_o, irq_o, wake_o, err;
  logic [CHAN_W-1:0] channel_sel_o;
  logic [PREF_W-1:0] pos_ref_sel_o;
  logic [RES_W-1:0] dac_trial_o;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int t0;
  sacc_row_t rows [5] = '{
    '{ADDR_CHAN, 32'h0000_003F, 32'h0000_003F, 1'h0},
    '{ADDR_CLKDIV, 32'h0000_002A, 32'h0000_002A, 1'h0},
    '{ADDR_THR, 32'h0000_0155, 32'h0000_0155, 1'h0},
    '{ADDR_RESL, 32'h0000_00FF, 32'h0000_0000, 1'h0},
    '{8'h40, 32'h0000_00FF, 32'h0000_0000, 1'h1}};

  sacc_top dut (.clock_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .rc_osc_i, .comparator_i, .sleep_i, .channel_sel_o,
    .pos_ref_sel_o, .neg_ref_sel_o, .sample_hold_o, .dac_trial_o, .irq_o, .wake_o);
  sacc_partner far (.clock_i, .rc_run_i(rc_run), .channel_i(channel_sel_o),
    .trial_i(dac_trial_o), .comp_o(comparator_i), .rc_osc_o(rc_osc_i));

  // Clock at 10 MHz and a cycle ceiling that cuts a hang short.
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen, then one idle cycle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'h1;
    do @(posedge clock_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clock_i);
  endtask : apb

  // One conversion on the divided clock: time, result bytes, go bit and flags.
  task automatic convert(input logic [5:0] ch, input logic [5:0] n, input logic [9:0] thr);
    logic [9:0] vin;
    vin = {ch, 4'h5};
    apb(1'h1, ADDR_CHAN, 32'h0);
    apb(1'h1, ADDR_CHAN, {26'h0, ch});
    repeat (20) @(posedge clock_i);
    apb(1'h1, ADDR_CLKDIV, {26'h0, n});
    apb(1'h1, ADDR_THR, {22'h0, thr});
    apb(1'h1, ADDR_MASK, 32'h0000_0001);
    t0 = cycles;
    apb(1'h1, ADDR_CTRL, 32'h0000_0003);
    while (irq_o !== 1'h1 && cycles - t0 < 2000) @(posedge clock_i);
    t0 = cycles - t0 - 23 * (n + 1);
    chk("conversion time", 32'h1, 32'(t0 >= 0 && t0 <= 10));
    apb(1'h0, ADDR_RESH, 32'h0);
    chk("result high", {30'h0, vin[9:8]}, rd);
    apb(1'h0, ADDR_RESL, 32'h0);
    chk("result low", {24'h0, vin[7:0]}, rd);
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk("go after done", 32'h0000_0001, rd);
    apb(1'h0, ADDR_STAT, 32'h0);
    chk("status", {30'h0, vin >= thr, 1'h1}, rd);
    apb(1'h1, ADDR_STAT, 32'h0000_0003);
    repeat (2) @(posedge clock_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
  endtask : convert

  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // Reset, register rows, reference codes, then conversions and faults.
  initial begin
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'h1;
    @(posedge clock_i);
    apb(1'h0, ADDR_THR, 32'h0);
    chk("threshold reset", 32'h0000_03FF, rd);
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].w);
      chk("error flag", 32'(rows[i].e), 32'(err));
      apb(1'h0, rows[i].a, 32'h0);
      chk("read back", rows[i].r, rd);
    end
    for (int i = 0; i < 10; i++) begin
      apb(1'h1, ADDR_REF, 32'(((i % 2) << 4) | (i / 2)));
      chk("positive ref", 32'(i / 2), 32'(pos_ref_sel_o));
      chk("negative ref", 32'(i % 2), 32'(neg_ref_sel_o));
    end
    convert(6'h2A, 6'h3F, 10'h3FF);
    convert(6'h3F, 6'h01, 10'h3FF);
    convert(6'h15, 6'h03, 10'h155);
    // Continuous mode with the interrupt masked: flag still sets, go stays up.
    apb(1'h1, ADDR_MASK, 32'h0);
    apb(1'h1, ADDR_CTRL, 32'h0000_0007);
    repeat (200) @(posedge clock_i);
    apb(1'h0, ADDR_STAT, 32'h0);
    chk("masked status", 32'h0000_0003, rd);
    chk("masked irq", 32'h0, 32'(irq_o));
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk("go continuous", 32'h0000_0007, rd);
    // Abort in mid-conversion: no flag may follow.
    t0 = cycles;
    while (sample_hold_o !== 1'h1 && cycles - t0 < 200) @(posedge clock_i);
    repeat (30) @(posedge clock_i);
    apb(1'h1, ADDR_CTRL, 32'h0000_0001);
    apb(1'h1, ADDR_STAT, 32'h0000_0003);
    repeat (150) @(posedge clock_i);
    apb(1'h0, ADDR_STAT, 32'h0);
    chk("status after abort", 32'h0, rd);
    // RC clock while asleep: the conversion finishes slower and wakes the device.
    apb(1'h1, ADDR_MASK, 32'h0000_0001);
    rc_run <= 1'h1;
    sleep_i <= 1'h1;
    t0 = cycles;
    apb(1'h1, ADDR_CTRL, 32'h0000_0013);
    while (wake_o !== 1'h1 && cycles - t0 < 1000) @(posedge clock_i);
    chk("wake", 32'h1, 32'(wake_o));
    chk("rc time", 32'h1, 32'(cycles - t0 > 150));
    sleep_i <= 1'h0;
    rc_run <= 1'h0;
    // Reset after the RC conversion brings channel_sel_o and the control register back to their reset values.
    reset_n_i <= 1'h0;
    repeat (2) @(posedge clock_i);
    chk("channel reset", 32'(CHAN_RST), 32'(channel_sel_o));
    reset_n_i <= 1'h1;
    @(posedge clock_i);
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk("control reset", 32'h0, rd);
    results();
  end
endmodule : test_sar_adc_clock_and_config
